// ==== klc_debounce.sv ====
`timescale 1ns/1ps
module klc_debounce
    import klc_pkg::*;
#(
    parameter int unsigned DB_CYC = KLC_DB_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Raw key pin
    input wire logic key_raw,
    // Cleaned key
    output logic key_lvl,
    output logic key_ev
);

    localparam logic [KLC_CNT_W-1:0] LAST = KLC_CNT_W'(DB_CYC - 1);

    logic sync1_q, sync2_q, lvl_q, ev_q;
    logic [KLC_CNT_W-1:0] cnt_q;

    wire same = sync2_q == lvl_q;
    wire stable = cnt_q >= LAST;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            lvl_q <= 1'b0;
            ev_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            sync1_q <= key_raw;
            sync2_q <= sync1_q;
            ev_q <= !same && stable && sync2_q;
            if (same || stable) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (!same && stable) begin
                lvl_q <= sync2_q;
            end
        end
    end

    assign key_lvl = lvl_q;
    assign key_ev = ev_q;

endmodule

// ==== klc_drive_model.sv ====
`timescale 1ns/1ps
module klc_drive_model
    import klc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Commands and fault stimulus
    input klc_cmd_t cmd,
    input wire logic trip_req,
    input wire logic trip_cause,
    // Status back to keypad
    output klc_drv_in_t drv
);
    logic [3:0] st_q;
    logic rev_q;
    logic ev_q;
    logic jog_q;
    // Actual direction lags the request by one cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= 4'h2;
            rev_q <= 1'b0;
            ev_q <= 1'b0;
            jog_q <= 1'b0;
        end else begin
            ev_q <= trip_req;
            rev_q <= cmd.dir_rev;
            jog_q <= cmd.jog;
            if (trip_req)
                st_q <= 4'h1;
            else if (cmd.trip_reset && !trip_cause && st_q == 4'h1)
                st_q <= 4'h2;
            // Only a trip reset leaves the tripped state
            else if ((cmd.run || cmd.jog) && st_q != 4'h1)
                st_q <= 4'h5;
            else if ((cmd.stop || jog_q) && st_q != 4'h1)
                st_q <= 4'h2;
        end
    end
    assign drv = '{state: st_q, stopped: st_q == 4'h2, act_rev: rev_q,
                   trip_active: trip_cause, trip_event: ev_q};
endmodule

// ==== klc_keypad.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Navigate: up/down move selection
// - Edit: up increments value
// - Edit: down decrements value
// - Command menu: up confirms action
// - Escape: menu up, or leave edit
// - Navigate: escape acknowledges shown trip message
// - Menu key descends or selects first entry
// - Menu edits writable parameter, shows mark
// - Toggle key swaps operator/other, keeps positions
// - Source key toggles sequence and reference together
// - Source key jumps to setpoint; local adjusts it
// - Direction key reverses, local reference only
// - Jog while held, stopped and local
// - Run key starts at setpoint speed
// - Run resets trips, then starts
// - Run honoured only with local sequence
// - Stop honoured only with local sequence
// - Stop resets trips, clears inactive message
// - Seven indicators: health/fwd/rev/run/stop off/flash/on, seq/ref off/on only
// - Nine drive states on health/run/stop
// - Four direction cases on fwd/rev
// - Local indicators show source combination
// - Power-up in remote, local keys inactive
// - Wrong-mode keys ignored, source key always
module klc_keypad
    import klc_pkg::*;
#(
    parameter int unsigned DB_CYC = KLC_DB_CYC,
    parameter int unsigned FLASH_CYC = KLC_FLASH_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [KLC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Key pins
    input wire logic [KLC_NKEYS-1:0] key_pin,
    // Drive sequencer
    input klc_drv_in_t drv,
    output klc_cmd_t cmd,
    // Display
    output klc_ui_t ui,
    // Indicators {health, seq, ref, fwd, rev, run, stop}
    output logic [KLC_NLEDS-1:0] led
);

    localparam logic [KLC_CNT_W-1:0] FLASH_LAST = KLC_CNT_W'(FLASH_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Key inputs

    logic [KLC_NKEYS-1:0] lv, ev;

    for (genvar i = 0; i < KLC_NKEYS; i++) begin : g_key
        klc_debounce #(
            .DB_CYC(DB_CYC)
        ) u_db (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .key_raw(key_pin[i]),
            .key_lvl(lv[i]),
            .key_ev(ev[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    klc_ui_mode_t mode_q, mode_d;
    klc_pos_t cur_q, cur_d, sav_q, sav_d;
    logic inop_q, inop_d;
    logic seq_q, ref_q, dir_q, trip_q, jog_q;
    logic run_pend_q;
    logic [2:0] ctrl_q;
    klc_cmd_t cmd_q;
    klc_ui_t ui_q, ui_d;
    logic [KLC_NLEDS-1:0] led_q;
    logic [KLC_CNT_W-1:0] flash_cnt_q;
    logic flash_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    wire writable = ctrl_q[KLC_CB_WR];
    wire cmd_menu = ctrl_q[KLC_CB_CMD];
    wire on_param = ctrl_q[KLC_CB_PAR];
    wire at_top = cur_q.level == '0;
    wire at_leaf = cur_q.level == KLC_MAX_LEVEL;
    wire run_acc = ev[K_RUN] && seq_q;
    wire stop_acc = ev[K_STOP] && seq_q;
    wire dir_acc = ev[K_DIR] && ref_q;
    wire jog_d = lv[K_JOG] && seq_q && (jog_q || drv.stopped);
    // A source key owns the cycle, so no silent clear
    wire esc_ack = trip_q && ev[K_ESC] && mode_q == UI_NAV &&
                   !ev[K_LR] && !ev[K_TOGGLE];
    wire stop_clr = stop_acc && !drv.trip_active;
    wire trip_d = drv.trip_event || (trip_q && !(esc_ack || stop_clr));

    ////////////////////////////////////////////////////////////////////////
    // Menu and edit handling

    always_comb begin
        mode_d = mode_q;
        cur_d = cur_q;
        sav_d = sav_q;
        inop_d = inop_q;
        ui_d = '0;
        if (ev[K_LR]) begin
            cur_d = KLC_SP_POS;
            inop_d = 1'b1;
            if (!inop_q) begin
                sav_d = cur_q;
            end
            mode_d = ref_q ? UI_NAV : UI_SETPT;
        end else if (ev[K_TOGGLE]) begin
            cur_d = sav_q;
            sav_d = cur_q;
            inop_d = !inop_q;
            mode_d = UI_NAV;
        end else begin
            case (mode_q)
                UI_EDIT: begin
                    ui_d.param_inc = ev[K_UP];
                    ui_d.param_dec = ev[K_DOWN];
                    if (ev[K_ESC]) begin
                        mode_d = UI_NAV;
                    end
                end
                UI_SETPT: begin
                    ui_d.sp_inc = ev[K_UP] && ref_q;
                    ui_d.sp_dec = ev[K_DOWN] && ref_q;
                    if (ev[K_ESC] || ev[K_MENU]) begin
                        mode_d = UI_NAV;
                    end
                end
                default: begin
                    if (esc_ack) begin
                        ui_d.trip_ack = 1'b1;
                    end else if (ev[K_UP] && cmd_menu) begin
                        ui_d.confirm = 1'b1;
                    end else if (ev[K_UP]) begin
                        cur_d.index = cur_q.index - 1'b1;
                    end else if (ev[K_DOWN]) begin
                        cur_d.index = cur_q.index + 1'b1;
                    end else if (ev[K_ESC] && !at_top) begin
                        cur_d.level = cur_q.level - 1'b1;
                        cur_d.index = '0;
                    end else if (ev[K_MENU]) begin
                        if (on_param) begin
                            if (writable) begin
                                mode_d = UI_EDIT;
                            end
                        end else begin
                            cur_d.index = '0;
                            if (!at_leaf) begin
                                cur_d.level = cur_q.level + 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
        ui_d.edit_mark = mode_d == UI_EDIT;
        ui_d.trip_shown = trip_d;
        ui_d.in_operator = inop_d;
        ui_d.pos = cur_d;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= UI_NAV;
            cur_q <= KLC_SP_POS;
            sav_q <= KLC_OTHER_INIT;
            inop_q <= 1'b1;
            ui_q <= '0;
            trip_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cur_q <= cur_d;
            sav_q <= sav_d;
            inop_q <= inop_d;
            ui_q <= ui_d;
            trip_q <= trip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Local control commands

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q <= 1'b0;
            ref_q <= 1'b0;
            dir_q <= 1'b0;
            jog_q <= 1'b0;
            run_pend_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            if (ev[K_LR]) begin
                seq_q <= !seq_q;
                ref_q <= !ref_q;
            end
            if (dir_acc) begin
                dir_q <= !dir_q;
            end
            jog_q <= jog_d;
            run_pend_q <= run_acc;
            cmd_q.trip_reset <= run_acc || stop_acc;
            cmd_q.run <= run_pend_q;
            cmd_q.stop <= stop_acc;
            cmd_q.jog <= jog_d;
            cmd_q.dir_rev <= dir_acc ? !dir_q : dir_q;
            cmd_q.seq_local <= ev[K_LR] ? !seq_q : seq_q;
            cmd_q.ref_local <= ev[K_LR] ? !ref_q : ref_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators

    wire [3:0] st = drv.state > KLC_ST_LAST ? '0 : drv.state;
    wire [5:0] hrs = KLC_HRS_PAT[st];
    wire [3:0] fr = KLC_DIR_PAT[{cmd_q.dir_rev, drv.act_rev}];
    wire [1:0] seq_code = cmd_q.seq_local ? LED_ON : LED_OFF;
    wire [1:0] ref_code = cmd_q.ref_local ? LED_ON : LED_OFF;
    wire [2*KLC_NLEDS-1:0] codes = {hrs[5:4], seq_code, ref_code, fr,
                                    hrs[3:0]};
    wire flash_wrap = flash_cnt_q >= FLASH_LAST;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else begin
            flash_cnt_q <= flash_wrap ? '0 : flash_cnt_q + 1'b1;
            flash_q <= flash_wrap ? !flash_q : flash_q;
        end
    end

    for (genvar i = 0; i < KLC_NLEDS; i++) begin : g_led
        wire [1:0] c = codes[2*i+:2];
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                led_q[i] <= 1'b0;
            end else begin
                led_q[i] <= c == LED_ON || (c == LED_FLASH && flash_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    wire apb_acc = psel && penable && !pready_q;
    wire apb_done = psel && penable && pready_q;
    wire hit_ctrl = paddr == KLC_CTRL_OFS;
    wire hit_stat = paddr == KLC_STAT_OFS;
    wire bad = !(hit_ctrl || (hit_stat && !pwrite));
    klc_stat_t stat;
    assign stat = '{rsvd: '0, pos: cur_q, in_op: inop_q,
                    trip_shown: trip_q, dir_rev: dir_q, ref_local: ref_q,
                    seq_local: seq_q, drv_state: drv.state, mode: mode_q};
    wire [31:0] rd_mux = hit_ctrl ? {29'h0000000, ctrl_q} :
                         hit_stat ? stat : '0;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            ctrl_q <= KLC_CTRL_RST;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && bad;
            prdata_q <= (apb_acc && !pwrite) ? rd_mux : '0;
            if (apb_done && pwrite && hit_ctrl) begin
                ctrl_q <= pwdata[2:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cmd = cmd_q;
    assign ui = ui_q;
    assign led = led_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_run_press;
        ev[K_RUN] && seq_q;
    endsequence

    sequence s_reset_then_run;
        cmd_q.trip_reset ##1 cmd_q.run;
    endsequence

    property p_run_seq;
        s_run_press |=> s_reset_then_run;
    endproperty
    a_run_seq: assert property (p_run_seq)
        else $error("run key did not reset then start");

    property p_run_remote;
        ev[K_RUN] && !seq_q && !ev[K_STOP] |=> !cmd_q.trip_reset ##1 !cmd_q.run;
    endproperty
    a_run_remote: assert property (p_run_remote)
        else $error("run key acted in remote");

    property p_stop_local;
        cmd_q.stop |-> $past(ev[K_STOP]) && $past(seq_q);
    endproperty
    a_stop_local: assert property (p_stop_local)
        else $error("stop issued without local key press");

    property p_jog;
        cmd_q.jog |-> $past(lv[K_JOG]) && $past(cmd_q.seq_local);
    endproperty
    a_jog: assert property (p_jog)
        else $error("jog without held key in local");

    property p_dir;
        $changed(cmd_q.dir_rev) |-> $past(ev[K_DIR]) && $past(ref_q);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction changed without local key");

    property p_same_src;
        cmd_q.seq_local == cmd_q.ref_local;
    endproperty
    a_same_src: assert property (p_same_src)
        else $error("sources out of step");

    property p_edit_entry;
        mode_q == UI_EDIT && $past(mode_q) == UI_NAV |-> $past(writable);
    endproperty
    a_edit_entry: assert property (p_edit_entry)
        else $error("edit entered on read-only parameter");

    property p_sp_local;
        ui_q.sp_inc || ui_q.sp_dec |-> $past(ref_q);
    endproperty
    a_sp_local: assert property (p_sp_local)
        else $error("setpoint adjusted in remote");

    property p_lr_jump;
        ev[K_LR] |=> cur_q == KLC_SP_POS && inop_q && ui_q.in_operator;
    endproperty
    a_lr_jump: assert property (p_lr_jump)
        else $error("source toggle did not show setpoint");

    property p_trip_set;
        drv.trip_event |=> trip_q && ui_q.trip_shown;
    endproperty
    a_trip_set: assert property (p_trip_set)
        else $error("trip message lost");

endmodule

// ==== klc_pkg.sv ====
package klc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned KLC_CLK_KHZ = 40000;
    localparam int unsigned KLC_DEBOUNCE_MS = 20;
    localparam int unsigned KLC_FLASH_HALF_MS = 250;
    localparam int unsigned KLC_DB_CYC = KLC_DEBOUNCE_MS * KLC_CLK_KHZ;
    localparam int unsigned KLC_FLASH_CYC = KLC_FLASH_HALF_MS * KLC_CLK_KHZ;
    localparam int unsigned KLC_CNT_W = 24;

    ////////////////////////////////////////////////////////////////////////
    // Keys
    localparam int unsigned KLC_NKEYS = 10;
    localparam int unsigned K_UP = 0;
    localparam int unsigned K_DOWN = 1;
    localparam int unsigned K_ESC = 2;
    localparam int unsigned K_MENU = 3;
    localparam int unsigned K_TOGGLE = 4;
    localparam int unsigned K_LR = 5;
    localparam int unsigned K_DIR = 6;
    localparam int unsigned K_JOG = 7;
    localparam int unsigned K_RUN = 8;
    localparam int unsigned K_STOP = 9;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    localparam int unsigned KLC_AW = 12;
    localparam logic [11:0] KLC_CTRL_OFS = 12'h000;
    localparam logic [11:0] KLC_STAT_OFS = 12'h004;
    localparam int unsigned KLC_CB_WR = 0;
    localparam int unsigned KLC_CB_CMD = 1;
    localparam int unsigned KLC_CB_PAR = 2;
    localparam logic [2:0] KLC_CTRL_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Menu position
    typedef struct packed {
        logic [2:0] level;
        logic [4:0] index;
    } klc_pos_t;

    localparam logic [2:0] KLC_MAX_LEVEL = 3'h4;
    localparam klc_pos_t KLC_SP_POS = '{level: 3'h1, index: 5'h00};
    localparam klc_pos_t KLC_OTHER_INIT = '{level: 3'h1, index: 5'h00};

    typedef enum logic [2:0] {
        UI_NAV = 3'b001,
        UI_EDIT = 3'b010,
        UI_SETPT = 3'b100
    } klc_ui_mode_t;

    ////////////////////////////////////////////////////////////////////////
    // Indicator codes and patterns {health, run, stop}
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_FLASH = 2'h1;
    localparam logic [1:0] LED_ON = 2'h2;
    localparam int unsigned KLC_NSTATES = 9;
    localparam int unsigned KLC_NLEDS = 7;
    localparam logic [3:0] KLC_ST_LAST = 4'h8;
    localparam logic [8:0][5:0] KLC_HRS_PAT = {
        {LED_FLASH, LED_FLASH, LED_FLASH},  // auto restart timing
        {LED_FLASH, LED_OFF, LED_FLASH},    // auto restart waiting
        {LED_ON, LED_FLASH, LED_FLASH},     // autotuning
        {LED_ON, LED_ON, LED_OFF},          // running
        {LED_ON, LED_FLASH, LED_ON},        // running, no demand
        {LED_ON, LED_FLASH, LED_OFF},       // stopping
        {LED_ON, LED_OFF, LED_ON},          // stopped
        {LED_FLASH, LED_OFF, LED_ON},       // tripped
        {LED_OFF, LED_OFF, LED_OFF}         // reconfiguration
    };
    // {fwd, rev} indexed by {requested reverse, actual reverse}
    localparam logic [3:0][3:0] KLC_DIR_PAT = {
        {LED_OFF, LED_ON},
        {LED_ON, LED_FLASH},
        {LED_FLASH, LED_ON},
        {LED_ON, LED_OFF}
    };

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [3:0] state;
        logic stopped;
        logic act_rev;
        logic trip_active;
        logic trip_event;
    } klc_drv_in_t;

    typedef struct packed {
        logic run;
        logic stop;
        logic trip_reset;
        logic jog;
        logic dir_rev;
        logic seq_local;
        logic ref_local;
    } klc_cmd_t;

    typedef struct packed {
        logic param_inc;
        logic param_dec;
        logic sp_inc;
        logic sp_dec;
        logic confirm;
        logic trip_ack;
        logic edit_mark;
        logic trip_shown;
        logic in_operator;
        klc_pos_t pos;
    } klc_ui_t;

    typedef struct packed {
        logic [11:0] rsvd;
        klc_pos_t pos;
        logic in_op;
        logic trip_shown;
        logic dir_rev;
        logic ref_local;
        logic seq_local;
        logic [3:0] drv_state;
        klc_ui_mode_t mode;
    } klc_stat_t;

endpackage

// ==== test_keypad_local_control.sv ====
`timescale 1ns/1ps
module test_keypad_local_control
    import klc_pkg::*;
;
    localparam int DB = 4;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [KLC_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [KLC_NKEYS-1:0] key_pin;
    logic trip_req, trip_cause, err;
    logic [7:0] rnd;
    logic [8:0] ev;
    logic [8:0] exp_q[$];
    klc_drv_in_t drv;
    klc_cmd_t cmd;
    klc_ui_t ui;
    logic [KLC_NLEDS-1:0] led;
    int fails = 0;
    int check_count = 0;

    klc_keypad #(.DB_CYC(DB), .FLASH_CYC(8)) u_klc_keypad (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_pin(key_pin), .drv(drv),
        .cmd(cmd), .ui(ui), .led(led));
    klc_drive_model u_klc_drive_model (
        .ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .trip_req(trip_req),
        .trip_cause(trip_cause), .drv(drv));

    assign ev = {cmd.run, cmd.stop, cmd.trip_reset, ui.param_inc,
                 ui.param_dec, ui.sp_inc, ui.sp_dec, ui.confirm, ui.trip_ack};

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // Pulses are only one cycle wide, so sample mid-cycle
    always @(negedge ref_clk) begin
        if (rstn === 1'b1 && ev !== 9'h000) begin
            if (exp_q.size() == 0)
                chk({23'h0, ev}, 32'h0);
            else
                chk({23'h0, ev}, {23'h0, exp_q.pop_front()});
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            print_verdict();
        end
    endtask

    // Hold long enough for sync plus debounce
    task automatic press(input int k);
        @(posedge ref_clk);
        key_pin[k] <= 1'b1;
        repeat (DB + 8) @(posedge ref_clk);
        key_pin[k] <= 1'b0;
        repeat (DB + 8) @(posedge ref_clk);
    endtask

    task automatic jog(input logic exp);
        key_pin[K_JOG] <= 1'b1;
        repeat (DB + 8) @(posedge ref_clk);
        chk(cmd.jog, exp);
        key_pin[K_JOG] <= 1'b0;
        repeat (DB + 8) @(posedge ref_clk);
        chk(cmd.jog, 0);
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        trip_req = 1'b0;
        trip_cause = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        key_pin = 10'h000;
        rnd = 8'h40;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk({cmd.seq_local, cmd.ref_local, led[5:4]}, 0);
        apb(1'b0, KLC_STAT_OFS, 32'h0);
        chk({err, rd}, 33'h000020811);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            // Random upper bits must not reach the stored field
            apb(1'b1, KLC_CTRL_OFS, {4{rnd}});
            apb(1'b0, KLC_CTRL_OFS, 32'h0);
            chk({err, rd}, {30'h0, rnd[2:0]});
        end
        apb(1'b0, 12'h008, 32'h0);
        chk({err, rd}, 33'h100000000);
        apb(1'b1, KLC_STAT_OFS, 32'h0);
        chk(err, 1);
        apb(1'b1, KLC_CTRL_OFS, 32'h0);
        press(K_RUN);
        press(K_DIR);
        chk(cmd.dir_rev, 0);
        press(K_DOWN);
        chk(ui.pos, {3'h1, 5'h01});
        press(K_UP);
        chk(ui.pos, {3'h1, 5'h00});
        press(K_MENU);
        chk(ui.pos.level, 2);
        press(K_ESC);
        chk(ui.pos.level, 1);
        apb(1'b1, KLC_CTRL_OFS, 32'h4);
        press(K_MENU);
        chk(ui.edit_mark, 0);
        apb(1'b1, KLC_CTRL_OFS, 32'h5);
        press(K_MENU);
        chk(ui.edit_mark, 1);
        exp_q.push_back(9'h020);
        press(K_UP);
        exp_q.push_back(9'h010);
        press(K_DOWN);
        press(K_ESC);
        chk(ui.edit_mark, 0);
        apb(1'b1, KLC_CTRL_OFS, 32'h2);
        exp_q.push_back(9'h002);
        press(K_UP);
        trip_req <= 1'b1;
        @(posedge ref_clk);
        trip_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(ui.trip_shown, 1);
        exp_q.push_back(9'h001);
        press(K_ESC);
        chk(ui.trip_shown, 0);
        apb(1'b1, KLC_CTRL_OFS, 32'h0);
        press(K_DOWN);
        press(K_TOGGLE);
        chk(ui.in_operator, 0);
        press(K_TOGGLE);
        chk({ui.in_operator, ui.pos}, {1'b1, 3'h1, 5'h01});
        press(K_LR);
        chk({cmd.seq_local, cmd.ref_local, led[5:4]}, 4'hF);
        chk(ui.pos, KLC_SP_POS);
        apb(1'b0, KLC_STAT_OFS, 32'h0);
        chk({err, rd}, 33'h00002098C);
        exp_q.push_back(9'h008);
        press(K_UP);
        exp_q.push_back(9'h004);
        press(K_DOWN);
        chk(led[3:2], 2'b10);
        press(K_DIR);
        chk({cmd.dir_rev, led[3:2]}, 3'b101);
        exp_q.push_back(9'h040);
        exp_q.push_back(9'h100);
        press(K_RUN);
        chk({led[6], led[1:0]}, 3'b110);
        jog(1'b0);
        trip_cause <= 1'b1;
        trip_req <= 1'b1;
        @(posedge ref_clk);
        trip_req <= 1'b0;
        exp_q.push_back(9'h0C0);
        press(K_STOP);
        chk({ui.trip_shown, led[1:0]}, 3'b101);
        trip_cause <= 1'b0;
        exp_q.push_back(9'h0C0);
        press(K_STOP);
        chk({ui.trip_shown, led[6], led[1:0]}, 4'b0101);
        jog(1'b1);
        press(K_LR);
        chk(cmd.seq_local, 0);
        press(K_STOP);
        chk(exp_q.size(), 0);
        print_verdict();
    end
endmodule
